// file: cmou_pkg.sv
package cmou_pkg;
   localparam int CMOU_WAYS = 4;
   localparam int CMOU_PTAG_W = 28;
   localparam int CMOU_STAG_W = 23;
   localparam int CMOU_PIDX_W = 9;
   localparam int CMOU_SIDX_W = 12;
   localparam int CMOU_XIDX_W = 14;
   localparam int CMOU_VA_W = 64;
   localparam int CMOU_PA_W = 40;
   localparam int CMOU_OFS_W = 16;

   localparam logic [4:0] CMOU_OP_I_IDX_INV = 5'h00;
   localparam logic [4:0] CMOU_OP_D_IDX_WBI = 5'h01;
   localparam logic [4:0] CMOU_OP_D_LD_TAG = 5'h05;
   localparam logic [4:0] CMOU_OP_D_ST_TAG = 5'h09;
   localparam logic [4:0] CMOU_OP_D_HIT_INV = 5'h11;
   localparam logic [4:0] CMOU_OP_D_HIT_WBI = 5'h15;
   localparam logic [4:0] CMOU_OP_D_LD_DAT = 5'h19;
   localparam logic [4:0] CMOU_OP_D_ST_DAT = 5'h1d;
   localparam logic [4:0] CMOU_OP_S_IDX_WBI = 5'h03;
   localparam logic [4:0] CMOU_OP_S_LD_TAG = 5'h07;
   localparam logic [4:0] CMOU_OP_S_ST_TAG = 5'h0b;
   localparam logic [4:0] CMOU_OP_S_HIT_INV = 5'h13;
   localparam logic [4:0] CMOU_OP_S_HIT_WBI = 5'h17;
   localparam logic [4:0] CMOU_OP_S_LD_DAT = 5'h1b;
   localparam logic [4:0] CMOU_OP_S_ST_DAT = 5'h1f;

   localparam logic [1:0] CMOU_ST_INV = 2'h0;
   localparam logic [1:0] CMOU_ST_DIRTY = 2'h3;
   localparam logic [31:0] CMOU_TAGREG_RST = 32'h0;

   // field positions inside the tag-low / tag-high pair
   localparam int CMOU_TLO_L2WAY_LSB = 4;
   localparam int CMOU_TLO_DST_LSB = 6;
   localparam int CMOU_TLO_DCACHE_TAG_LSB = 8;
   localparam int CMOU_TLO_SST_LSB = 10;
   localparam int CMOU_TLO_STAG_LSB = 13;
   localparam int CMOU_THI_TAGX_LSB = 0;
   localparam int CMOU_THI_SMOD_LSB = 29;

   typedef struct packed {
      logic valid;
      logic [4:0] op;
      logic [63:0] base;
      logic [15:0] offset;
   } cmou_req_s;

   typedef struct packed {
      logic valid;
      logic [63:0] va;
   } cmou_tlbreq_s;

   typedef struct packed {
      logic valid;
      logic [39:0] pa;
   } cmou_tlbrsp_s;

   typedef struct packed {
      logic lo_we;
      logic hi_we;
      logic [31:0] data;
   } cmou_cpw_s;

   typedef struct packed {
      logic valid;
      logic we;
      logic tag_we;
      logic [8:0] idx;
      logic [3:0] wmask;
      logic [27:0] tag;
      logic [1:0] state;
      logic [1:0] l2way;
      logic par;
   } cmou_preq_s;

   typedef struct packed {
      logic valid;
      logic [3:0][27:0] tag;
      logic [3:0][1:0] state;
      logic [3:0][1:0] l2way;
      logic [3:0][2:0] smod;
   } cmou_prsp_s;

   typedef struct packed {
      logic valid;
      logic we;
      logic [11:0] idx;
      logic [1:0] way;
      logic [22:0] tag;
      logic [1:0] state;
   } cmou_sreq_s;

   typedef struct packed {
      logic valid;
      logic [3:0][22:0] tag;
      logic [3:0][1:0] state;
   } cmou_srsp_s;

   typedef struct packed {
      logic valid;
      logic we;
      logic l2;
      logic [13:0] idx;
      logic [1:0] way;
      logic [63:0] wdata;
   } cmou_xreq_s;

   typedef struct packed {
      logic valid;
      logic [63:0] rdata;
   } cmou_xrsp_s;

   typedef struct packed {
      logic valid;
      logic [11:0] idx;
      logic [1:0] way;
   } cmou_wbreq_s;
endpackage

// file: cmou_way_hit.sv
module cmou_way_hit #(
   parameter int WAYS = 4,
   parameter int TW = 28
) (
   input wire logic [WAYS-1:0][TW-1:0] tag,
   input wire logic [WAYS-1:0] live,
   input wire logic [TW-1:0] cmp,
   output logic [WAYS-1:0] hit
);
   if (WAYS < 1 || TW < 1) begin : g_chk
      $error("cmou_way_hit: WAYS and TW must be positive");
   end

   always_comb begin
      for (int i = 0; i < WAYS; i++) begin
         hit[i] = live[i] && (tag[i] == cmp);
      end
   end
endmodule // cmou_way_hit

// file: cmou_top.sv
module cmou_top #(
   parameter int WAYS = cmou_pkg::CMOU_WAYS
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire cmou_pkg::cmou_req_s op_req,
   output logic op_busy,
   output logic op_done,
   input wire cmou_pkg::cmou_cpw_s cp_wr,
   output logic [31:0] cache_tag_low,
   output logic [31:0] cache_tag_high,
   output cmou_pkg::cmou_tlbreq_s tlb_req,
   input wire cmou_pkg::cmou_tlbrsp_s tlb_rsp,
   output cmou_pkg::cmou_preq_s ic_req,
   input wire cmou_pkg::cmou_prsp_s ic_rsp,
   output cmou_pkg::cmou_preq_s dc_req,
   input wire cmou_pkg::cmou_prsp_s dc_rsp,
   output cmou_pkg::cmou_sreq_s sc_req,
   input wire cmou_pkg::cmou_srsp_s sc_rsp,
   output cmou_pkg::cmou_xreq_s dat_req,
   input wire cmou_pkg::cmou_xrsp_s dat_rsp,
   output cmou_pkg::cmou_wbreq_s dwb_req,
   input wire logic dwb_ack,
   output cmou_pkg::cmou_wbreq_s siu_req,
   input wire logic siu_ack
);
   import cmou_pkg::*;

   if (WAYS != CMOU_WAYS) begin : g_chk
      $error("cmou_top: only four ways are supported");
   end

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_XLATE,
      ST_SCHK,
      ST_IRD,
      ST_ICHK,
      ST_DRD,
      ST_DCHK,
      ST_DWB,
      ST_DWR,
      ST_SWR,
      ST_SIU,
      ST_LDD,
      ST_DONE
   } cmou_st_e;

   typedef struct packed {
      cmou_st_e st;
      logic [4:0] op;
      logic [63:0] va;
      logic [39:0] pa;
      logic [31:0] tlo;
      logic [31:0] thi;
      cmou_tlbreq_s tlb;
      cmou_preq_s ireq;
      cmou_preq_s dreq;
      cmou_sreq_s sreq;
      cmou_xreq_s xreq;
      cmou_wbreq_s dwb;
      cmou_wbreq_s siu;
      logic busy;
      logic done;
      logic [22:0] stag;
      logic [1:0] sway;
      logic [1:0] sstate;
      logic [1:0] dway;
   } cmou_state_s;

   cmou_state_s s_q;
   cmou_state_s s_d;
   logic rst_meta_q;
   logic rst_sync_q;
   logic [3:0] i_live;
   logic [3:0] d_live;
   logic [3:0] s_live;
   logic [3:0] i_hit;
   logic [3:0] d_hit;
   logic [3:0] s_hit;
   logic [27:0] s_ptag;
   logic [27:0] d_cmp;
   logic s_seq;
   logic wb_op;

   function automatic logic [1:0] first_way(input logic [3:0] m);
      logic [1:0] w;
      w = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (m[i]) begin
            w = 2'(i);
         end
      end
      return w;
   endfunction

   function automatic logic [3:0] way_onehot(input logic [1:0] w);
      logic [3:0] m;
      m = 4'h0;
      m[w] = 1'b1;
      return m;
   endfunction

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // primary tag of the secondary block: the stored secondary tag stag then pa[16:12]
   assign s_ptag = {s_q.stag, s_q.pa[16:12]};
   assign s_seq = s_q.op[1];
   assign d_cmp = s_seq ? s_ptag : s_q.pa[39:12];
   assign wb_op = (s_q.op == CMOU_OP_D_IDX_WBI) || (s_q.op == CMOU_OP_D_HIT_WBI)
      || (s_q.op == CMOU_OP_S_IDX_WBI) || (s_q.op == CMOU_OP_S_HIT_WBI);

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         i_live[i] = ic_rsp.state[i][0];
         d_live[i] = dc_rsp.state[i] != CMOU_ST_INV;
         s_live[i] = sc_rsp.state[i] != CMOU_ST_INV;
      end
   end

   cmou_way_hit #(.WAYS(4), .TW(CMOU_PTAG_W)) u_ihit (
      .tag(ic_rsp.tag),
      .live(i_live),
      .cmp(s_ptag),
      .hit(i_hit)
   );

   cmou_way_hit #(.WAYS(4), .TW(CMOU_PTAG_W)) u_dhit (
      .tag(dc_rsp.tag),
      .live(d_live),
      .cmp(d_cmp),
      .hit(d_hit)
   );

   cmou_way_hit #(.WAYS(4), .TW(CMOU_STAG_W)) u_shit (
      .tag(sc_rsp.tag),
      .live(s_live),
      .cmp(s_q.pa[39:17]),
      .hit(s_hit)
   );

   always_comb begin
      logic [63:0] va_n;
      logic [3:0] sel;
      logic [1:0] w;
      va_n = '0;
      sel = '0;
      w = '0;
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.ireq.valid = 1'b0;
      s_d.dreq.valid = 1'b0;
      s_d.dreq.tag_we = 1'b0;
      s_d.sreq.valid = 1'b0;
      s_d.xreq.valid = 1'b0;
      // moves to the tag pair; software must not overlap them with a running op
      if (cp_wr.lo_we) begin
         s_d.tlo = cp_wr.data;
      end
      if (cp_wr.hi_we) begin
         s_d.thi = cp_wr.data;
      end
      case (s_q.st)
         ST_IDLE: begin
            if (op_req.valid) begin
               va_n = op_req.base + {{48{op_req.offset[15]}}, op_req.offset};
               s_d.op = op_req.op;
               s_d.va = va_n;
               s_d.tlb.valid = 1'b1;
               s_d.tlb.va = va_n;
               s_d.busy = 1'b1;
               s_d.st = ST_XLATE;
            end
         end
         ST_XLATE: begin
            if (tlb_rsp.valid) begin
               s_d.tlb.valid = 1'b0;
               s_d.pa = tlb_rsp.pa;
               s_d.st = ST_DONE;
               case (s_q.op)
                  CMOU_OP_I_IDX_INV: begin
                     s_d.ireq.valid = 1'b1;
                     s_d.ireq.we = 1'b1;
                     s_d.ireq.tag_we = 1'b0;
                     s_d.ireq.idx = s_q.va[13:5];
                     s_d.ireq.wmask = 4'hf;
                     s_d.ireq.state = CMOU_ST_INV;
                  end
                  CMOU_OP_D_IDX_WBI, CMOU_OP_D_LD_TAG,
                  CMOU_OP_D_HIT_INV, CMOU_OP_D_HIT_WBI: begin
                     s_d.dreq.valid = 1'b1;
                     s_d.dreq.we = 1'b0;
                     s_d.dreq.idx = s_q.va[13:5];
                     s_d.st = ST_DCHK;
                  end
                  CMOU_OP_D_ST_TAG: begin
                     s_d.dreq.valid = 1'b1;
                     s_d.dreq.we = 1'b1;
                     s_d.dreq.tag_we = 1'b1;
                     s_d.dreq.idx = s_q.va[13:5];
                     s_d.dreq.wmask = way_onehot(s_q.va[1:0]);
                     s_d.dreq.l2way = s_q.tlo[CMOU_TLO_L2WAY_LSB +: 2];
                     s_d.dreq.state = s_q.tlo[CMOU_TLO_DST_LSB +: 2];
                     s_d.dreq.tag = {s_q.thi[CMOU_THI_TAGX_LSB +: 4],
                        s_q.tlo[CMOU_TLO_DCACHE_TAG_LSB +: 24]};
                     s_d.dreq.par = 1'b0;
                  end
                  CMOU_OP_D_LD_DAT, CMOU_OP_S_LD_DAT,
                  CMOU_OP_D_ST_DAT, CMOU_OP_S_ST_DAT: begin
                     s_d.xreq.valid = 1'b1;
                     s_d.xreq.we = s_q.op[2];
                     s_d.xreq.l2 = s_q.op[1];
                     s_d.xreq.idx = s_q.op[1] ? s_q.va[16:3] : {3'h0, s_q.va[13:3]};
                     s_d.xreq.way = s_q.va[1:0];
                     s_d.xreq.wdata = {s_q.thi, s_q.tlo};
                     s_d.st = s_q.op[2] ? ST_DONE : ST_LDD;
                  end
                  CMOU_OP_S_IDX_WBI, CMOU_OP_S_LD_TAG,
                  CMOU_OP_S_HIT_INV, CMOU_OP_S_HIT_WBI: begin
                     s_d.sreq.valid = 1'b1;
                     s_d.sreq.we = 1'b0;
                     s_d.sreq.idx = tlb_rsp.pa[16:5];
                     s_d.sreq.way = tlb_rsp.pa[1:0];
                     s_d.st = ST_SCHK;
                  end
                  CMOU_OP_S_ST_TAG: begin
                     // the store-tag set is pa[13:5]; the upper set bits stay zero
                     s_d.sreq.valid = 1'b1;
                     s_d.sreq.we = 1'b1;
                     s_d.sreq.idx = {3'h0, tlb_rsp.pa[13:5]};
                     s_d.sreq.way = tlb_rsp.pa[1:0];
                     s_d.sreq.state = s_q.tlo[CMOU_TLO_SST_LSB +: 2];
                     s_d.sreq.tag = {s_q.thi[CMOU_THI_TAGX_LSB +: 4],
                        s_q.tlo[CMOU_TLO_STAG_LSB +: 19]};
                  end
                  default: begin
                     s_d.st = ST_DONE;
                  end
               endcase
            end
         end
         ST_SCHK: begin
            if (sc_rsp.valid) begin
               w = s_q.pa[1:0];
               if (s_q.op == CMOU_OP_S_LD_TAG) begin
                  s_d.tlo = '0;
                  s_d.thi = '0;
                  s_d.tlo[CMOU_TLO_SST_LSB +: 2] = sc_rsp.state[w];
                  s_d.tlo[CMOU_TLO_STAG_LSB +: 19] = sc_rsp.tag[w][18:0];
                  s_d.thi[CMOU_THI_TAGX_LSB +: 4] = sc_rsp.tag[w][22:19];
                  s_d.st = ST_DONE;
               end else begin
                  sel = (s_q.op == CMOU_OP_S_IDX_WBI) ? (way_onehot(w) & s_live) : s_hit;
                  if (sel == 4'h0) begin
                     s_d.st = ST_DONE;
                  end else begin
                     w = first_way(sel);
                     s_d.sway = w;
                     s_d.stag = sc_rsp.tag[w];
                     s_d.sstate = sc_rsp.state[w];
                     s_d.st = ST_IRD;
                  end
               end
            end
         end
         ST_IRD: begin
            s_d.ireq.valid = 1'b1;
            s_d.ireq.we = 1'b0;
            s_d.ireq.idx = s_q.pa[13:5];
            s_d.st = ST_ICHK;
         end
         ST_ICHK: begin
            if (ic_rsp.valid) begin
               if (i_hit != 4'h0) begin
                  s_d.ireq.valid = 1'b1;
                  s_d.ireq.we = 1'b1;
                  s_d.ireq.wmask = i_hit;
                  s_d.ireq.state = CMOU_ST_INV;
               end
               s_d.st = ST_DRD;
            end
         end
         ST_DRD: begin
            s_d.dreq.valid = 1'b1;
            s_d.dreq.we = 1'b0;
            s_d.dreq.idx = s_q.pa[13:5];
            s_d.st = ST_DCHK;
         end
         ST_DCHK: begin
            if (dc_rsp.valid) begin
               w = s_q.va[1:0];
               if (s_q.op == CMOU_OP_D_LD_TAG) begin
                  s_d.tlo = '0;
                  s_d.thi = '0;
                  s_d.tlo[CMOU_TLO_L2WAY_LSB +: 2] = dc_rsp.l2way[w];
                  s_d.tlo[CMOU_TLO_DST_LSB +: 2] = dc_rsp.state[w];
                  s_d.tlo[CMOU_TLO_DCACHE_TAG_LSB +: 24] = dc_rsp.tag[w][23:0];
                  s_d.thi[CMOU_THI_TAGX_LSB +: 4] = dc_rsp.tag[w][27:24];
                  s_d.thi[CMOU_THI_SMOD_LSB +: 3] = dc_rsp.smod[w];
                  s_d.st = ST_DONE;
               end else begin
                  sel = (s_q.op == CMOU_OP_D_IDX_WBI) ? (way_onehot(w) & d_live) : d_hit;
                  if (sel == 4'h0) begin
                     s_d.st = s_seq ? ST_SWR : ST_DONE;
                  end else begin
                     w = first_way(sel);
                     s_d.dway = w;
                     // only the first matching way is handled; two live copies cannot exist
                     if (wb_op && dc_rsp.state[w] == CMOU_ST_DIRTY) begin
                        s_d.dwb.valid = 1'b1;
                        s_d.dwb.idx = {3'h0, s_q.dreq.idx};
                        s_d.dwb.way = w;
                        s_d.st = ST_DWB;
                     end else begin
                        s_d.st = ST_DWR;
                     end
                  end
               end
            end
         end
         ST_DWB: begin
            if (dwb_ack) begin
               s_d.dwb.valid = 1'b0;
               s_d.st = ST_DWR;
            end
         end
         ST_DWR: begin
            s_d.dreq.valid = 1'b1;
            s_d.dreq.we = 1'b1;
            s_d.dreq.wmask = way_onehot(s_q.dway);
            s_d.dreq.state = CMOU_ST_INV;
            s_d.dreq.par = 1'b0;
            s_d.st = s_seq ? ST_SWR : ST_DONE;
         end
         ST_SWR: begin
            s_d.sreq.valid = 1'b1;
            s_d.sreq.we = 1'b1;
            s_d.sreq.way = s_q.sway;
            s_d.sreq.state = CMOU_ST_INV;
            s_d.sreq.tag = (s_q.op == CMOU_OP_S_IDX_WBI) ? s_q.stag : s_q.pa[39:17];
            s_d.st = ST_DONE;
            if (s_q.sstate == CMOU_ST_DIRTY && s_q.op != CMOU_OP_S_HIT_INV) begin
               s_d.siu.valid = 1'b1;
               s_d.siu.idx = s_q.sreq.idx;
               s_d.siu.way = s_q.sway;
               s_d.st = ST_SIU;
            end
         end
         ST_SIU: begin
            if (siu_ack) begin
               s_d.siu.valid = 1'b0;
               s_d.st = ST_DONE;
            end
         end
         ST_LDD: begin
            if (dat_rsp.valid) begin
               s_d.thi = dat_rsp.rdata[63:32];
               s_d.tlo = dat_rsp.rdata[31:0];
               s_d.st = ST_DONE;
            end
         end
         ST_DONE: begin
            s_d.done = 1'b1;
            s_d.busy = 1'b0;
            s_d.st = ST_IDLE;
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign op_busy = s_q.busy;
   assign op_done = s_q.done;
   assign cache_tag_low = s_q.tlo;
   assign cache_tag_high = s_q.thi;
   assign tlb_req = s_q.tlb;
   assign ic_req = s_q.ireq;
   assign dc_req = s_q.dreq;
   assign sc_req = s_q.sreq;
   assign dat_req = s_q.xreq;
   assign dwb_req = s_q.dwb;
   assign siu_req = s_q.siu;
endmodule // cmou_top

// file: cmou_chk.sv
module cmou_chk (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire cmou_pkg::cmou_req_s op_req,
   input wire logic op_busy,
   input wire logic op_done,
   input wire cmou_pkg::cmou_cpw_s cp_wr,
   input wire logic [31:0] cache_tag_low,
   input wire logic [31:0] cache_tag_high,
   input wire cmou_pkg::cmou_tlbreq_s tlb_req,
   input wire cmou_pkg::cmou_tlbrsp_s tlb_rsp,
   input wire cmou_pkg::cmou_preq_s dc_req,
   input wire cmou_pkg::cmou_xreq_s dat_req,
   input wire cmou_pkg::cmou_wbreq_s siu_req,
   input wire logic siu_ack
);
   import cmou_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   a_va_form: assert property (op_req.valid && !op_busy |=> op_busy && tlb_req.valid
      && tlb_req.va == $past(op_req.base) + {{48{$past(op_req.offset[15])}}, $past(op_req.offset)})
      else $error("translation address wrong");
   a_tlb_hold: assert property (tlb_req.valid && !tlb_rsp.valid
      |=> tlb_req.valid && $stable(tlb_req.va)) else $error("translation request dropped");
   a_tlb_drop: assert property (tlb_req.valid && tlb_rsp.valid |=> !tlb_req.valid)
      else $error("translation request held");
   a_done_pulse: assert property (op_done |-> !op_busy && $past(op_busy) ##1 !op_done)
      else $error("done pulse wrong");
   a_dcache_tag_store: assert property (dc_req.valid && dc_req.tag_we |-> dc_req.we
      && dc_req.tag == {cache_tag_high[3:0], cache_tag_low[31:8]}
      && dc_req.state == cache_tag_low[7:6] && dc_req.l2way == cache_tag_low[5:4])
      else $error("data tag store fields wrong");
   a_dc_inval: assert property (dc_req.valid && dc_req.we && !dc_req.tag_we
      |-> dc_req.state == CMOU_ST_INV && !dc_req.par && $onehot(dc_req.wmask))
      else $error("invalidate write wrong");
   a_data_store: assert property (dat_req.valid && dat_req.we
      |-> dat_req.wdata == {cache_tag_high, cache_tag_low}) else $error("store data wrong");
   a_siu_end: assert property (siu_req.valid && siu_ack
      |=> !siu_req.valid ##1 op_done) else $error("interface write-back not last");
   a_cp_write: assert property (cp_wr.lo_we && !op_busy
      |=> cache_tag_low == $past(cp_wr.data)) else $error("tag-low write lost");
endmodule // cmou_chk

bind cmou_top cmou_chk u_chk (.ref_clk, .rst_n, .op_req, .op_busy, .op_done, .cp_wr,
   .cache_tag_low, .cache_tag_high, .tlb_req, .tlb_rsp, .dc_req, .dat_req, .siu_req, .siu_ack);

// file: cmou_far.sv
module cmou_far #(
   parameter logic [39:0] XLAT = 40'h0
) (
   input wire logic ref_clk,
   input wire logic [1:0] slow,
   input wire cmou_pkg::cmou_prsp_s pimg,
   input wire cmou_pkg::cmou_srsp_s simg,
   input wire logic [63:0] ximg,
   input wire cmou_pkg::cmou_tlbreq_s tlb_req,
   output cmou_pkg::cmou_tlbrsp_s tlb_rsp,
   input wire cmou_pkg::cmou_preq_s ic_req,
   output cmou_pkg::cmou_prsp_s ic_rsp,
   input wire cmou_pkg::cmou_preq_s dc_req,
   output cmou_pkg::cmou_prsp_s dc_rsp,
   input wire cmou_pkg::cmou_sreq_s sc_req,
   output cmou_pkg::cmou_srsp_s sc_rsp,
   input wire cmou_pkg::cmou_xreq_s dat_req,
   output cmou_pkg::cmou_xrsp_s dat_rsp,
   input wire cmou_pkg::cmou_wbreq_s dwb_req,
   output logic dwb_ack,
   input wire cmou_pkg::cmou_wbreq_s siu_req,
   output logic siu_ack
);
   import cmou_pkg::*;
   localparam int PW = $bits(cmou_prsp_s) - 1;
   localparam int SW = $bits(cmou_srsp_s) - 1;
   initial begin
      tlb_rsp = '0;
      ic_rsp = '0;
      dc_rsp = '0;
      sc_rsp = '0;
      dat_rsp = '0;
      dwb_ack = 1'b0;
      siu_ack = 1'b0;
   end
   // answers carry inverted data once released, so stale values never pass
   always @(posedge ref_clk) begin
      if (tlb_req.valid) begin
         repeat (slow) @(posedge ref_clk);
         tlb_rsp <= {1'b1, tlb_req.va[39:0] ^ XLAT};
         @(posedge ref_clk);
         tlb_rsp <= {1'b0, ~tlb_rsp.pa};
      end
   end
   always @(posedge ref_clk) begin
      if (ic_req.valid && !ic_req.we) begin
         repeat (slow) @(posedge ref_clk);
         ic_rsp <= {1'b1, pimg[PW-1:0]};
         @(posedge ref_clk);
         ic_rsp <= {1'b0, ~pimg[PW-1:0]};
      end
   end
   always @(posedge ref_clk) begin
      if (dc_req.valid && !dc_req.we) begin
         repeat (slow) @(posedge ref_clk);
         dc_rsp <= {1'b1, pimg[PW-1:0]};
         @(posedge ref_clk);
         dc_rsp <= {1'b0, ~pimg[PW-1:0]};
      end
   end
   always @(posedge ref_clk) begin
      if (sc_req.valid && !sc_req.we) begin
         repeat (slow) @(posedge ref_clk);
         sc_rsp <= {1'b1, simg[SW-1:0]};
         @(posedge ref_clk);
         sc_rsp <= {1'b0, ~simg[SW-1:0]};
      end
   end
   always @(posedge ref_clk) begin
      if (dat_req.valid && !dat_req.we) begin
         repeat (slow) @(posedge ref_clk);
         dat_rsp <= {1'b1, ximg};
         @(posedge ref_clk);
         dat_rsp <= {1'b0, ~ximg};
      end
   end
   always @(posedge ref_clk) begin
      if (dwb_req.valid) begin
         repeat (slow) @(posedge ref_clk);
         dwb_ack <= 1'b1;
         @(posedge ref_clk);
         dwb_ack <= 1'b0;
      end
   end
   always @(posedge ref_clk) begin
      if (siu_req.valid) begin
         repeat (slow) @(posedge ref_clk);
         siu_ack <= 1'b1;
         @(posedge ref_clk);
         siu_ack <= 1'b0;
      end
   end
endmodule // cmou_far

// file: cache_maintenance_op_unit_bench.sv
module cache_maintenance_op_unit_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import cmou_pkg::*;
   localparam logic [39:0] XL = 40'ha5_0000_0000;
   localparam logic [4:0] DOPS [4] = '{CMOU_OP_D_LD_DAT, CMOU_OP_S_LD_DAT, CMOU_OP_D_ST_DAT,
      CMOU_OP_S_ST_DAT};
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic op_busy, op_done, dwb_ack, siu_ack;
   logic [1:0] slow = 2'h0;
   logic [1:0] w;
   logic [31:0] cache_tag_low, cache_tag_high, mlo, mhi;
   logic [63:0] ximg = '0;
   logic [63:0] b, va;
   logic [39:0] pa;
   logic [15:0] o;
   cmou_req_s op_req = '0;
   cmou_cpw_s cp_wr = '0;
   cmou_tlbreq_s tlb_req;
   cmou_tlbrsp_s tlb_rsp;
   cmou_preq_s ic_req, dc_req, icw, dcw;
   cmou_prsp_s ic_rsp, dc_rsp;
   cmou_prsp_s pimg = '0;
   cmou_sreq_s sc_req, scw;
   cmou_srsp_s sc_rsp;
   cmou_srsp_s simg = '0;
   cmou_xreq_s dat_req, xw;
   cmou_xrsp_s dat_rsp;
   cmou_wbreq_s dwb_req, siu_req;
   int fails = 0;
   int comparisons = 0;
   int n_ic = 0, n_dc = 0, n_wb = 0, n_siu = 0, k0, k1;
   integer seed = 32'h8782c059;
   always #20 ref_clk = ~ref_clk;
   cmou_top uut (.ref_clk, .rst_n, .op_req, .op_busy, .op_done, .cp_wr, .cache_tag_low,
      .cache_tag_high, .tlb_req, .tlb_rsp, .ic_req, .ic_rsp, .dc_req, .dc_rsp, .sc_req,
      .sc_rsp, .dat_req, .dat_rsp, .dwb_req, .dwb_ack, .siu_req, .siu_ack);
   cmou_far #(.XLAT(XL)) far (.ref_clk, .slow, .pimg, .simg, .ximg, .tlb_req, .tlb_rsp,
      .ic_req, .ic_rsp, .dc_req, .dc_rsp, .sc_req, .sc_rsp, .dat_req, .dat_rsp, .dwb_req,
      .dwb_ack, .siu_req, .siu_ack);
   // last request seen on each array port; in a sequence that writes a port, its write comes last
   always @(posedge ref_clk) begin
      if (ic_req.valid) begin
         icw <= ic_req;
         n_ic <= n_ic + 1;
      end
      if (dc_req.valid) begin
         dcw <= dc_req;
         n_dc <= n_dc + 1;
      end
      if (sc_req.valid) scw <= sc_req;
      if (dat_req.valid) xw <= dat_req;
      if (dwb_req.valid && dwb_ack) n_wb <= n_wb + 1;
      if (siu_req.valid && siu_ack) n_siu <= n_siu + 1;
   end
   task automatic check(input logic [95:0] seen, input logic [95:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic newaddr;
      b = {$random(seed), $random(seed)};
      o = 16'($random(seed));
      va = b + {{48{o[15]}}, o};
      pa = va[39:0] ^ XL;
      pimg = $bits(pimg)'({5{$random(seed)}});
      simg = $bits(simg)'({4{$random(seed)}});
      k0 = n_wb;
      k1 = n_siu;
   endtask
   task automatic run(input logic [4:0] op);
      int k = 0;
      @(posedge ref_clk);
      op_req <= '{1'b1, op, b, o};
      @(posedge ref_clk);
      op_req.valid <= 1'b0;
      #1;
      while (!op_done && k < 200) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      check(op_done, 1'b1);
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      for (int i = 0; i < 2; i++) begin
         slow <= i[0] ? 2'h2 : 2'h0;
         newaddr;
         mlo = $random(seed);
         mhi = $random(seed);
         @(posedge ref_clk);
         cp_wr <= '{1'b1, 1'b0, mlo};
         @(posedge ref_clk);
         cp_wr <= '{1'b0, 1'b1, mhi};
         @(posedge ref_clk);
         cp_wr <= '0;
         #1;
         check({cache_tag_high, cache_tag_low}, {mhi, mlo});
         run(CMOU_OP_D_ST_TAG);
         check({dcw.we, dcw.tag_we, dcw.idx, dcw.wmask, dcw.tag, dcw.state, dcw.l2way},
            {2'h3, va[13:5], 4'h1 << va[1:0], mhi[3:0], mlo[31:8], mlo[7:6], mlo[5:4]});
         run(CMOU_OP_S_ST_TAG);
         check({scw.we, scw.idx, scw.way, scw.tag, scw.state},
            {1'b1, 3'h0, pa[13:5], pa[1:0], mhi[3:0], mlo[31:13], mlo[11:10]});
         foreach (DOPS[j]) begin
            newaddr;
            ximg = {$random(seed), $random(seed)};
            run(DOPS[j]);
            if (!DOPS[j][2]) {mhi, mlo} = ximg;
            check({xw.we, xw.l2, xw.idx, xw.way}, {DOPS[j][2:1],
               DOPS[j][1] ? va[16:3] : {3'h0, va[13:3]}, va[1:0]});
            check({cache_tag_high, cache_tag_low}, {mhi, mlo});
            if (DOPS[j][2]) check(xw.wdata, {mhi, mlo});
         end
         newaddr;
         w = va[1:0];
         run(CMOU_OP_D_LD_TAG);
         check({cache_tag_high, cache_tag_low}, {pimg.smod[w], 25'h0, pimg.tag[w][27:24],
            pimg.tag[w][23:0], pimg.state[w], pimg.l2way[w], 4'h0});
         w = pa[1:0];
         run(CMOU_OP_S_LD_TAG);
         check({cache_tag_high, cache_tag_low, scw.idx, scw.way}, {28'h0, simg.tag[w][22:19],
            simg.tag[w][18:0], 1'b0, simg.state[w], 10'h0, pa[16:5], pa[1:0]});
         run(CMOU_OP_I_IDX_INV);
         check({icw.we, icw.idx, icw.wmask, icw.state[0]}, {1'b1, va[13:5], 5'h1e});
         w = va[1:0];
         pimg.state[w] = CMOU_ST_DIRTY;
         run(CMOU_OP_D_IDX_WBI);
         check({dcw.we, dcw.tag_we, dcw.idx, dcw.wmask, dcw.state, 32'(n_wb - k0)},
            {2'h2, va[13:5], 4'h1 << w, 2'h0, 32'h1});
         for (int j = 0; j < 2; j++) begin
            newaddr;
            pimg.tag[0] = pa[39:12];
            pimg.state[0] = CMOU_ST_INV;
            pimg.tag[2] = pa[39:12];
            pimg.state[2] = CMOU_ST_DIRTY;
            run(j ? CMOU_OP_D_HIT_WBI : CMOU_OP_D_HIT_INV);
            check({dcw.we, dcw.tag_we, dcw.idx, dcw.wmask, dcw.state, 32'(n_wb - k0)},
               {2'h2, va[13:5], 4'h4, 2'h0, 32'(j)});
         end
         newaddr;
         simg.state = '0;
         k0 = n_ic + n_dc;
         run(CMOU_OP_S_IDX_WBI);
         check({32'(n_ic + n_dc - k0), 32'(n_siu - k1)}, 64'h0);
         for (int j = 0; j < 2; j++) begin
            newaddr;
            simg.state = '0;
            simg.tag[1] = pa[39:17];
            simg.state[1] = CMOU_ST_DIRTY;
            pimg.tag[3] = pa[39:12];
            pimg.state[3] = CMOU_ST_DIRTY;
            run(j ? CMOU_OP_S_HIT_WBI : CMOU_OP_S_HIT_INV);
            check({icw.we, icw.idx, icw.wmask}, {1'b1, pa[13:5], 4'h8});
            check({dcw.we, dcw.idx, dcw.wmask, dcw.state, dcw.par, 32'(n_wb - k0)},
               {1'b1, pa[13:5], 4'h8, 3'h0, 32'(j)});
            check({scw.we, scw.idx, scw.way, scw.tag, scw.state, 32'(n_siu - k1)},
               {1'b1, pa[16:5], 2'h1, pa[39:17], 2'h0, 32'(j)});
         end
      end
      end_sim;
   end
   // ceiling well above the few hundred cycles needed
   initial begin
      #400us;
      fails++;
      end_sim;
   end
endmodule // cache_maintenance_op_unit_bench
